// file: logic/htt_home.sv
/*
 * home end: tracker entries with per-entry timers, sweep counter, error status,
 * viral marking of completions and the address decoder table.
 * assumes requesters keep their tags inside the range of the mode and that
 * the interval tick arrives asynchronously on a pin.
 */
`timescale 1ns/10ps
module htt_home #(
    parameter int COUNT_W = `HTT_COUNT_W
) (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic ARST_N_IN,
    // configuration
    input wire htt_pkg::htt_mode_t ALLOC_MODE_IN,
    input wire logic [63:0] TIMEOUT_VALUES_IN,
    input wire logic [1:0] SWEEP_SELECT_IN,
    input wire logic SYSTEM_INTERVAL_TICK_IN,
    // error sources and status
    input wire logic PARITY_ERR_IN,
    input wire logic ERR_CLEAR_IN,
    output logic ERR_PARITY_OUT,
    output logic ERR_TIMEOUT_OUT,
    output logic [7:0] ERR_ENTRY_OUT,
    output logic TIMEOUT_EVENT_OUT,
    output logic BAD_REQ_OUT,
    output htt_pkg::htt_mode_t MODE_OUT,
    // address decoder table
    input wire logic DEC_WRITE_IN,
    input wire logic [2:0] DEC_ENTRY_IN,
    input wire htt_pkg::htt_dec_entry_t DEC_DATA_IN,
    output htt_pkg::htt_dec_entry_t DEC_DATA_OUT,
    // fabric link
    htt_link_if.home_end link
);
    import htt_pkg::*;

    // refuse widths whose sweep taps would fall outside the counter
    if (COUNT_W < 11 || COUNT_W > 30) begin : g_bad_count_w
        $error("COUNT_W must lie between 11 and 30");
    end

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    typedef struct packed {
        logic init_done;
        htt_mode_t mode;
        logic [`HTT_ENTRIES-1:0] valid;
        logic [`HTT_ENTRIES-1:0][`HTT_TIMER_W-1:0] timer;
        htt_dec_entry_t [`HTT_DEC_ENTRIES-1:0] dec;
        htt_dec_entry_t dec_rd;
        logic [COUNT_W-1:0] count;
        logic tick_d;
        logic tap_d;
        logic scan_active;
        logic [7:0] scan_ptr;
        logic viral;
        logic err_parity;
        logic err_timeout;
        logic [7:0] err_entry;
        logic to_evt;
        logic bad_req;
        logic cmp_valid;
        htt_tag_t cmp_tag;
        htt_node_t cmp_node;
        logic cmp_viral;
    } htt_home_st_t;

    htt_home_st_t st;
    htt_home_st_t next_st;
    logic tick_s;

    // -------------------------------------------------------------------
    // tag and node to tracker entry
    // -------------------------------------------------------------------
    // returns {in_range, entry}; hubs and node controllers share a slot
    function automatic logic [8:0] map_entry(input htt_mode_t mode, input htt_node_t node,
                                             input htt_tag_t tag);
        logic [3:0] ca_n;
        logic [5:0] ca_sz;
        logic [3:0] hub_n;
        logic [5:0] hub_sz;
        logic [8:0] hub_base;
        logic [8:0] ca_base;
        logic [8:0] idx;
        logic ok;
        ca_n = 4'h4;
        ca_sz = 6'h20;
        hub_n = 4'h4;
        hub_sz = 6'h20;
        hub_base = 9'h080;
        unique case (mode)
            3'h1: begin
                ca_sz = 6'h30;
                hub_n = 4'h2;
                hub_base = 9'h0c0;
            end
            3'h2: begin
                ca_n = 4'h8;
                ca_sz = 6'h18;
                hub_n = 4'h2;
                hub_base = 9'h0c0;
            end
            3'h3: begin
                ca_n = 4'h8;
                ca_sz = 6'h10;
            end
            3'h4: begin
                ca_n = 4'h8;
                ca_sz = 6'h18;
                hub_sz = 6'h10;
                hub_base = 9'h0c0;
            end
            3'h5: begin
                ca_n = 4'h8;
                ca_sz = node[2] ? 6'h10 : 6'h20;
                hub_sz = 6'h10;
                hub_base = 9'h0c0;
            end
            default: begin
                ca_n = 4'h4;
            end
        endcase
        ca_base = 9'(node[2:0]) * 9'(ca_sz);
        if (mode == 3'h5) begin
            ca_base = node[2] ? 9'(9'h080 + 9'({node[1:0], 4'h0}))
                              : 9'({node[1:0], 5'h00});
        end
        if (!node[`HTT_HUB_BIT]) begin
            ok = ({1'b0, node[2:0]} < ca_n) && (tag < ca_sz);
            idx = 9'(ca_base + 9'(tag));
        end else begin
            ok = ({1'b0, node[2:0]} < hub_n) && (tag < hub_sz);
            idx = 9'(hub_base + 9'(9'(node[2:0]) * 9'(hub_sz)) + 9'(tag));
        end
        return {ok, idx[7:0]};
    endfunction

    // -------------------------------------------------------------------
    // interval tick input
    // -------------------------------------------------------------------
    htt_sync3 u_tick_sync (
        .clk_in(CLK_IN),
        .arst_n_in(ARST_N_IN),
        .d_in(SYSTEM_INTERVAL_TICK_IN),
        .q_out(tick_s)
    );

    // -------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------
    always_comb begin
        logic [8:0] req_map;
        logic [8:0] rsp_map;
        logic [7:0] ptr;
        logic tap;
        htt_level_t lvl;
        req_map = '0;
        rsp_map = '0;
        ptr = '0;
        tap = 1'b0;
        lvl = '0;
        next_st = st;
        next_st.to_evt = 1'b0;
        next_st.bad_req = 1'b0;
        next_st.cmp_valid = 1'b0;

        // mode is captured once, at the first edge after reset release
        if (!st.init_done) begin
            next_st.init_done = 1'b1;
            next_st.mode = (ALLOC_MODE_IN > `HTT_MODE_MAX) ? 3'h0 : ALLOC_MODE_IN;
        end

        // free-running counter and sweep tap
        next_st.tick_d = tick_s;
        if (tick_s && !st.tick_d) begin
            next_st.count = COUNT_W'(st.count + 1'b1);
        end
        unique case (SWEEP_SELECT_IN)
            2'b11: tap = next_st.count[COUNT_W-1];
            2'b10: tap = next_st.count[COUNT_W-1-`HTT_TAP_STEP];
            2'b01: tap = next_st.count[COUNT_W-1-2*`HTT_TAP_STEP];
            2'b00: tap = next_st.count[COUNT_W-1-3*`HTT_TAP_STEP];
        endcase
        next_st.tap_d = tap;
        if (st.tap_d && !tap && !st.scan_active) begin
            next_st.scan_active = 1'b1;
            next_st.scan_ptr = 8'h00;
        end

        rsp_map = map_entry(st.mode, link.rsp_node, link.rsp_tag);

        // error status clears first so a same-cycle event still lands
        if (ERR_CLEAR_IN) begin
            next_st.err_parity = 1'b0;
            next_st.err_timeout = 1'b0;
        end

        // sweep one entry per cycle
        if (st.scan_active) begin
            ptr = st.scan_ptr;
            if (st.valid[ptr] && !(link.rsp_valid && rsp_map[8] && rsp_map[7:0] == ptr)) begin
                if (st.timer[ptr] <= 8'h01) begin
                    next_st.timer[ptr] = 8'h00;
                    next_st.valid[ptr] = 1'b0;
                    next_st.err_timeout = 1'b1;
                    next_st.err_entry = ptr;
                    next_st.to_evt = 1'b1;
                end else begin
                    next_st.timer[ptr] = 8'(st.timer[ptr] - 8'h01);
                end
            end
            next_st.scan_ptr = 8'(st.scan_ptr + 8'h01);
            if (st.scan_ptr == 8'hff) begin
                next_st.scan_active = 1'b0;
            end
        end

        // new transaction, coherent or not, on the request channel
        if (link.req_valid) begin
            req_map = map_entry(st.mode, link.req_node, link.req_tag);
            lvl = (!link.req_write && !link.req_noncoh) ? `HTT_HOME_LEVEL
                                                        : link.req_level;
            if (req_map[8]) begin
                next_st.valid[req_map[7:0]] = 1'b1;
                next_st.timer[req_map[7:0]] = TIMEOUT_VALUES_IN[{lvl, 3'b000} +: 8];
            end else begin
                next_st.bad_req = 1'b1;
            end
        end

        // timed message arrives on the data response channel
        if (link.rsp_valid) begin
            if (rsp_map[8]) begin
                next_st.valid[rsp_map[7:0]] = 1'b0;
            end
            next_st.cmp_valid = 1'b1;
            next_st.cmp_tag = link.rsp_tag;
            next_st.cmp_node = link.rsp_node;
        end

        if (PARITY_ERR_IN) begin
            next_st.err_parity = 1'b1;
            next_st.viral = 1'b1;
        end
        next_st.cmp_viral = next_st.viral;

        // address decoder table
        next_st.dec_rd = st.dec[DEC_ENTRY_IN];
        if (DEC_WRITE_IN) begin
            next_st.dec[DEC_ENTRY_IN] = DEC_DATA_IN;
        end
    end

    // -------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------
    localparam htt_dec_entry_t DEC_RST = '{`HTT_DEC_LIMIT_RST, `HTT_DEC_BASE_RST,
                                          `HTT_DEC_SHIFT_RST, `HTT_DEC_NXM_RST};

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            st <= '0;
            st.dec <= {`HTT_DEC_ENTRIES{DEC_RST}};
            st.dec_rd <= DEC_RST;
        end else begin
            st <= next_st;
        end
    end

    // -------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------
    assign ERR_PARITY_OUT = st.err_parity;
    assign ERR_TIMEOUT_OUT = st.err_timeout;
    assign ERR_ENTRY_OUT = st.err_entry;
    assign TIMEOUT_EVENT_OUT = st.to_evt;
    assign BAD_REQ_OUT = st.bad_req;
    assign MODE_OUT = st.mode;
    assign DEC_DATA_OUT = st.dec_rd;
    assign link.cmp_valid = st.cmp_valid;
    assign link.cmp_tag = st.cmp_tag;
    assign link.cmp_node = st.cmp_node;
    assign link.cmp_viral = st.cmp_viral;
endmodule // htt_home

// file: logic/htt_link_if.sv
/*
 * coherent fabric link between a requester and the home tracker logic.
 * assumes one shared clock; the testbench ties both modports together.
 */
`timescale 1ns/10ps
interface htt_link_if;
    import htt_pkg::*;
    // home request channel
    logic req_valid;
    htt_tag_t req_tag;
    htt_node_t req_node;
    logic req_write;
    logic req_noncoh;
    htt_level_t req_level;
    // data response channel, the message being timed
    logic rsp_valid;
    htt_tag_t rsp_tag;
    htt_node_t rsp_node;
    // completion packets from the home
    logic cmp_valid;
    htt_tag_t cmp_tag;
    htt_node_t cmp_node;
    logic cmp_viral;

    modport home_end (
        input req_valid, req_tag, req_node, req_write, req_noncoh, req_level,
        input rsp_valid, rsp_tag, rsp_node,
        output cmp_valid, cmp_tag, cmp_node, cmp_viral
    );
    modport requester_end (
        output req_valid, req_tag, req_node, req_write, req_noncoh, req_level,
        output rsp_valid, rsp_tag, rsp_node,
        input cmp_valid, cmp_tag, cmp_node, cmp_viral
    );
endinterface // htt_link_if

// file: logic/htt_params.svh
/*
 * constants of the home tracker time-out block: sizes, reset values, sweep taps.
 * assumes inclusion by the package and by every module of the block.
 */
// Behaviour
// - decoder entries reset to full-range local memory
// - 256 tracker entries, one per tag/node pair
// - allocation mode fixed once at initialization
// - modes 0 and 1 partition sizes
// - modes 2 and 3 partition sizes
// - modes 4 and 5 partition sizes
// - requesters issue only tags their mode allows
// - node controller id is hub id plus bit4
// - non-coherent requests share request and data channels
// - requester can promote non-coherent to coherent
// - internal parity error logged in error status
// - after parity error all outgoing packets viral
// - timer loaded from eight 8-bit programmable values
// - sweep decrements timers; zero means timed out
// - free-running 30-bit counter ticks on interval clock
// - select code picks sweep tap bit 30/27/24/21; the code taps counter bits 29/26/23/20
// - timed message received invalidates its entry
// - home applies time-out level 2
// - requesters use levels 1, 3 and 4
`ifndef HTT_PARAMS_SVH
`define HTT_PARAMS_SVH

`define HTT_ENTRIES 256
`define HTT_LEVELS 8
`define HTT_TIMER_W 8
`define HTT_COUNT_W 30
`define HTT_HOME_LEVEL 3'h2
`define HTT_LEVEL_WRITE 3'h1
`define HTT_LEVEL_READ 3'h3
`define HTT_LEVEL_IO 3'h4
`define HTT_MODE_MAX 3'h5
`define HTT_NC_BIT 4
`define HTT_HUB_BIT 3
`define HTT_DEC_ENTRIES 8
`define HTT_DEC_LIMIT_RST 16'hffff
`define HTT_DEC_BASE_RST 12'h000
`define HTT_DEC_SHIFT_RST 4'h0
`define HTT_DEC_NXM_RST 1'h0
// tap distance below the counter top for select codes 11, 10, 01, 00
`define HTT_TAP_STEP 3

`endif

// file: logic/htt_pkg.sv
/*
 * types shared by both ends of the home tracker time-out block.
 * assumes the constants header is on the include path.
 */
package htt_pkg;
`include "htt_params.svh"

    // -------------------------------------------------------------------
    // address decoder entry
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] limit;
        logic [11:0] base;
        logic [3:0] shift;
        logic nonexistent_memory_flag;
    } htt_dec_entry_t;

    typedef logic [5:0] htt_tag_t;
    typedef logic [4:0] htt_node_t;
    typedef logic [2:0] htt_level_t;
    typedef logic [2:0] htt_mode_t;
endpackage

// file: logic/htt_requester.sv
/*
 * requester end: checks tag ranges, forms node ids, promotes non-coherent
 * requests when disabled and picks its time-out level.
 * assumes user-side inputs come from logic on the same clock.
 */
`timescale 1ns/10ps
module htt_requester (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic ARST_N_IN,
    // configuration
    input wire htt_pkg::htt_mode_t ALLOC_MODE_IN,
    input wire logic NONCOH_DISABLE_IN,
    input wire logic NODE_CONTROLLER_IN,
    // issue side
    input wire logic ISSUE_VALID_IN,
    input wire htt_pkg::htt_node_t ISSUE_NODE_IN,
    input wire htt_pkg::htt_tag_t ISSUE_TAG_IN,
    input wire logic ISSUE_WRITE_IN,
    input wire logic ISSUE_NONCOH_IN,
    input wire logic ISSUE_IO_IN,
    output logic ISSUE_REJECT_OUT,
    // data response side
    input wire logic RESP_VALID_IN,
    input wire htt_pkg::htt_node_t RESP_NODE_IN,
    input wire htt_pkg::htt_tag_t RESP_TAG_IN,
    // completions
    output logic DONE_VALID_OUT,
    output htt_pkg::htt_tag_t DONE_TAG_OUT,
    output htt_pkg::htt_node_t DONE_NODE_OUT,
    output logic DONE_VIRAL_OUT,
    // fabric link
    htt_link_if.requester_end link
);
    import htt_pkg::*;

    typedef struct packed {
        logic req_valid;
        htt_tag_t req_tag;
        htt_node_t req_node;
        logic req_write;
        logic req_noncoh;
        htt_level_t req_level;
        logic rsp_valid;
        htt_tag_t rsp_tag;
        htt_node_t rsp_node;
        logic reject;
        logic done_valid;
        htt_tag_t done_tag;
        htt_node_t done_node;
        logic done_viral;
    } htt_req_st_t;

    htt_req_st_t st;
    htt_req_st_t next_st;

    // -------------------------------------------------------------------
    // tags allowed per mode, as a count
    // -------------------------------------------------------------------
    function automatic logic [6:0] tag_limit(input htt_mode_t mode, input htt_node_t node);
        logic [6:0] lim;
        lim = 7'h20;
        if (!node[`HTT_HUB_BIT]) begin
            unique case (mode)
                3'h1: lim = 7'h30;
                3'h2: lim = 7'h18;
                3'h3: lim = 7'h10;
                3'h4: lim = 7'h18;
                3'h5: lim = node[2] ? 7'h10 : 7'h20;
                default: lim = 7'h20;
            endcase
        end else if (mode == 3'h4 || mode == 3'h5) begin
            lim = 7'h10;
        end
        return lim;
    endfunction

    // -------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------
    always_comb begin
        htt_node_t node;
        node = ISSUE_NODE_IN;
        next_st = st;
        next_st.req_valid = 1'b0;
        next_st.reject = 1'b0;
        next_st.rsp_valid = 1'b0;
        next_st.done_valid = 1'b0;
        // node controller answers under its hub's id with bit 4 set
        node[`HTT_NC_BIT] = NODE_CONTROLLER_IN && ISSUE_NODE_IN[`HTT_HUB_BIT];
        if (ISSUE_VALID_IN) begin
            if ({1'b0, ISSUE_TAG_IN} < tag_limit(ALLOC_MODE_IN, node)) begin
                next_st.req_valid = 1'b1;
                next_st.req_tag = ISSUE_TAG_IN;
                next_st.req_node = node;
                next_st.req_write = ISSUE_WRITE_IN;
                next_st.req_noncoh = ISSUE_NONCOH_IN && !NONCOH_DISABLE_IN;
                if (ISSUE_IO_IN) begin
                    next_st.req_level = `HTT_LEVEL_IO;
                end else if (ISSUE_WRITE_IN || next_st.req_noncoh) begin
                    next_st.req_level = `HTT_LEVEL_WRITE;
                end else begin
                    next_st.req_level = `HTT_LEVEL_READ;
                end
            end else begin
                next_st.reject = 1'b1;
            end
        end
        if (RESP_VALID_IN) begin
            next_st.rsp_valid = 1'b1;
            next_st.rsp_tag = RESP_TAG_IN;
            next_st.rsp_node = RESP_NODE_IN;
            next_st.rsp_node[`HTT_NC_BIT] = NODE_CONTROLLER_IN && RESP_NODE_IN[`HTT_HUB_BIT];
        end
        if (link.cmp_valid) begin
            next_st.done_valid = 1'b1;
            next_st.done_tag = link.cmp_tag;
            next_st.done_node = link.cmp_node;
            next_st.done_viral = link.cmp_viral;
        end
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // -------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------
    assign link.req_valid = st.req_valid;
    assign link.req_tag = st.req_tag;
    assign link.req_node = st.req_node;
    assign link.req_write = st.req_write;
    assign link.req_noncoh = st.req_noncoh;
    assign link.req_level = st.req_level;
    assign link.rsp_valid = st.rsp_valid;
    assign link.rsp_tag = st.rsp_tag;
    assign link.rsp_node = st.rsp_node;
    assign ISSUE_REJECT_OUT = st.reject;
    assign DONE_VALID_OUT = st.done_valid;
    assign DONE_TAG_OUT = st.done_tag;
    assign DONE_NODE_OUT = st.done_node;
    assign DONE_VIRAL_OUT = st.done_viral;
endmodule // htt_requester

// file: logic/htt_sync3.sv
/*
 * three-stage synchroniser with agreement filter.
 * assumes an input from outside the clock domain.
 */
`timescale 1ns/10ps
module htt_sync3 (
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // level
    input wire logic d_in,
    output logic q_out
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } htt_sync_st_t;

    htt_sync_st_t st;
    htt_sync_st_t next_st;

    always_comb begin
        next_st = st;
        next_st.s1 = d_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        if (st.s2 == st.s3) begin
            next_st.q = st.s3;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q_out = st.q;
endmodule // htt_sync3

// file: tb/home_tracker_timeout_test.sv
/*
 * testbench joining requester and home ends through the link.
 * assumes COUNT_W of 11 so that select 00 sweeps every 4 ticks.
 */
`timescale 1ns/10ps
module home_tracker_timeout_test;
    import htt_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, tick = 1'b0, par = 1'b0, clr = 1'b0;
    logic iv = 1'b0, iw = 1'b0, inc = 1'b0, rv = 1'b0, rej, dv, dvir, ep, et, ev, bad;
    logic ncd = 1'b0, nctl = 1'b0, iio = 1'b0, dw = 1'b0;
    logic [63:0] tov = '0;
    logic [7:0] ee;
    htt_node_t in_n = '0, rn = '0, dn;
    htt_tag_t it = '0, rt = '0, dt;
    htt_mode_t mo;
    htt_dec_entry_t dd;
    logic [2:0] de = 3'h0;
    htt_dec_entry_t ddi = '0;
    logic [11:0] done_q[$];
    logic [7:0] to_q[$];
    int failures = 0, samples_checked = 0, cycles = 0;
    htt_link_if link_bus ();
    htt_requester u_htt_requester (.CLK_IN(clk), .ARST_N_IN(rst_n), .ALLOC_MODE_IN(3'h1),
        .NONCOH_DISABLE_IN(ncd), .NODE_CONTROLLER_IN(nctl), .ISSUE_VALID_IN(iv),
        .ISSUE_NODE_IN(in_n), .ISSUE_TAG_IN(it), .ISSUE_WRITE_IN(iw), .ISSUE_NONCOH_IN(inc),
        .ISSUE_IO_IN(iio), .ISSUE_REJECT_OUT(rej), .RESP_VALID_IN(rv), .RESP_NODE_IN(rn),
        .RESP_TAG_IN(rt), .DONE_VALID_OUT(dv), .DONE_TAG_OUT(dt), .DONE_NODE_OUT(dn),
        .DONE_VIRAL_OUT(dvir), .link(link_bus));
    htt_home #(.COUNT_W(11)) u_htt_home (.CLK_IN(clk), .ARST_N_IN(rst_n), .ALLOC_MODE_IN(3'h1),
        .TIMEOUT_VALUES_IN(tov), .SWEEP_SELECT_IN(2'h0), .SYSTEM_INTERVAL_TICK_IN(tick),
        .PARITY_ERR_IN(par), .ERR_CLEAR_IN(clr), .ERR_PARITY_OUT(ep), .ERR_TIMEOUT_OUT(et),
        .ERR_ENTRY_OUT(ee), .TIMEOUT_EVENT_OUT(ev), .BAD_REQ_OUT(bad), .MODE_OUT(mo),
        .DEC_WRITE_IN(dw), .DEC_ENTRY_IN(de), .DEC_DATA_IN(ddi), .DEC_DATA_OUT(dd),
        .link(link_bus));
    htt_link_assertions u_htt_link_assertions (.CLK_IN(clk), .ARST_N_IN(rst_n),
        .req_valid(link_bus.req_valid), .req_tag(link_bus.req_tag),
        .req_node(link_bus.req_node), .req_noncoh(link_bus.req_noncoh),
        .req_level(link_bus.req_level), .rsp_valid(link_bus.rsp_valid),
        .rsp_tag(link_bus.rsp_tag), .rsp_node(link_bus.rsp_node),
        .cmp_valid(link_bus.cmp_valid), .cmp_tag(link_bus.cmp_tag),
        .cmp_node(link_bus.cmp_node), .cmp_viral(link_bus.cmp_viral));
    always #5 clk = ~clk;
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("failures=%0d samples_checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    task automatic issue(input htt_node_t n, input htt_tag_t t, input logic nc, input logic r);
        in_n = n;
        it = t;
        inc = nc;
        iv = 1'b1;
        step();
        check(rej, r);
        iv = 1'b0;
        step();
    endtask
    task automatic resp(input htt_node_t n, input htt_tag_t t, input logic vir);
        done_q.push_back({vir, nctl, n[3:0], t});
        rn = n;
        rt = t;
        rv = 1'b1;
        step();
        rv = 1'b0;
        step();
    endtask
    // ------------------------------------------------------------
    // monitors
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            stop_test();
        end
        if (dv === 1'b1) begin
            check(done_q.size() > 0, 1'b1);
            if (done_q.size() > 0) check({dvir, dn, dt}, done_q.pop_front());
        end
        if (ev === 1'b1) begin
            check(to_q.size() > 0, 1'b1);
            if (to_q.size() > 0) check({et, ee}, {1'b1, to_q.pop_front()});
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hb56f));
        tov = {24'($urandom()), 8'h01, 8'hff, 8'h01, 8'hff, 8'hff};
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        step();
        for (int i = 0; i < 8; i++) begin
            de = i[2:0];
            step();
            check(dd, {16'hffff, 12'h000, 4'h0, 1'b0});
        end
        check(mo, 3'h1);
        ddi = {$urandom(), 1'b1};
        dw = 1'b1;
        step();
        dw = 1'b0;
        step();
        check(dd, ddi);
        issue(5'h00, 6'h05, 1'b0, 1'b0);
        issue(5'h02, 6'h28, 1'b0, 1'b0);
        issue(5'h08, 6'h02, 1'b0, 1'b0);
        issue(5'h00, 6'h07, 1'b0, 1'b0);
        issue(5'h01, 6'h03, 1'b1, 1'b0);
        ncd = 1'b1;
        issue(5'h01, 6'h04, 1'b1, 1'b0);
        ncd = 1'b0;
        iw = 1'b1;
        issue(5'h09, 6'h06, 1'b0, 1'b0);
        iio = 1'b1;
        issue(5'h09, 6'h07, 1'b0, 1'b0);
        iw = 1'b0;
        iio = 1'b0;
        issue(5'h0a, 6'h01, 1'b0, 1'b0);
        check(bad, 1'b1);
        issue(5'h00, 6'h30, 1'b0, 1'b1);
        issue(5'h08, 6'h20, 1'b0, 1'b1);
        issue(5'h03, {1'b0, 5'($urandom())}, 1'b0, 1'b0);
        resp(5'h00, 6'h07, 1'b0);
        // entries left holding timer value 1, in sweep order
        to_q = {8'h05, 8'h34, 8'h88, 8'(8'h90 + 8'(it)), 8'hc2, 8'he7};
        repeat (8) begin
            tick = 1'b1;
            repeat (4) step();
            tick = 1'b0;
            repeat (4) step();
        end
        for (int i = 0; i < 600 && to_q.size() > 0; i++) step();
        check(to_q.size(), 0);
        par = 1'b1;
        step();
        par = 1'b0;
        step();
        check(ep, 1'b1);
        clr = 1'b1;
        step();
        clr = 1'b0;
        step();
        check({ep, et}, 2'h0);
        resp(5'h00, 6'h09, 1'b1);
        nctl = 1'b1;
        issue(5'h09, 6'h05, 1'b0, 1'b0);
        resp(5'h08, 6'h03, 1'b1);
        repeat (4) step();
        check(done_q.size(), 0);
        stop_test();
    end
endmodule // home_tracker_timeout_test

// file: tb/htt_link_assertions.sv
/*
 * checker for the link between requester end and home end.
 * assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/10ps
module htt_link_assertions (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic ARST_N_IN,
    // link signals
    input wire logic req_valid,
    input wire htt_pkg::htt_tag_t req_tag,
    input wire htt_pkg::htt_node_t req_node,
    input wire logic req_noncoh,
    input wire htt_pkg::htt_level_t req_level,
    input wire logic rsp_valid,
    input wire htt_pkg::htt_tag_t rsp_tag,
    input wire htt_pkg::htt_node_t rsp_node,
    input wire logic cmp_valid,
    input wire htt_pkg::htt_tag_t cmp_tag,
    input wire htt_pkg::htt_node_t cmp_node,
    input wire logic cmp_viral
);
    import htt_pkg::*;
    logic viral_seen;
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!ARST_N_IN);
    // remembers that a viral completion went out
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            viral_seen <= 1'b0;
        end else if (cmp_valid && cmp_viral) begin
            viral_seen <= 1'b1;
        end
    end
    sequence s_rsp;
        rsp_valid;
    endsequence
    sequence s_cmp;
        cmp_valid && cmp_tag == $past(rsp_tag) && cmp_node == $past(rsp_node);
    endsequence
    a_rsp_gives_cmp: assert property (s_rsp |=> s_cmp)
        else $error("response without matching completion");
    a_cmp_needs_rsp: assert property (cmp_valid |-> $past(rsp_valid))
        else $error("completion without response");
    a_viral_sticks: assert property (cmp_valid && viral_seen |-> cmp_viral)
        else $error("viral mark dropped");
    a_cacher_tag_range: assert property (req_valid |-> req_tag < 6'h30)
        else $error("request tag out of range");
    a_hub_tag_range: assert property (req_valid && req_node[3] |-> req_tag < 6'h20)
        else $error("hub tag out of range");
    a_level_legal: assert property (req_valid |-> req_level inside {3'h1, 3'h3, 3'h4})
        else $error("requester level illegal");
    a_noncoh_level: assert property (req_valid && req_noncoh |-> req_level == 3'h1)
        else $error("non-coherent level wrong");
    a_ctrl_is_hub: assert property (req_valid && req_node[4] |-> req_node[3])
        else $error("controller id not a hub id");
endmodule // htt_link_assertions
